// File: hdl/eee_regs.sv
/*
  eee_dsp_config_registers: configuration bank for energy-efficient ethernet
  and the 100M timing loop, written over the management register port.
  reserved bits read zero; unmapped offsets read zero and ignore writes.
  assumes: REG_WE/REG_RE pulse on MCLK from logic on the same clock;
  clause-45 capability and advertisement come in as same-clock inputs.
*/
// Function
// R1: Bit 3 set takes ability from bit 0, clear from clause-45 registers.
// R2: Bit 2 clear keeps eee next-page reception; set blocks it.
// R3: Bit 1 set powers analog rx down in quiet; clear keeps it active.
// R4: Bit 0 clear reports no eee and ignores clause-45 capability/advert.
// R5: Bit 0 set negotiates eee per the two advertisement registers.
// R6: Wake fallback bit 8 reset 1; mse timer bits 7-4 reset 8.
// R7: Link register resets 0x354a; two 5-bit timers reset 10.
// R8: Flush dir, toggle, fast wake, descrambler timeout, pre-flush fields.
// R9: Step 0/1 register resets 0x6633, four 3-bit gains, reserved gaps.
// R10: Step 2 register resets 0x2f1 with gains and step fields.
// R11: Step 3 register resets 0x171, same layout, bits 15-10 reserved.
// R12: Forced select 0 normal, 3 forced lpi; tx request honoured only then.
// R13: Reserved bits read zero and ignore writes.
`default_nettype none
module eee_dsp_config_registers
  import eee_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        SRST,
  // register port
  input  wire logic [15:0] REG_ADDR,
  input  wire logic        REG_WE,
  input  wire logic        REG_RE,
  input  wire logic [15:0] REG_WDATA,
  output logic [15:0]      REG_RDATA,
  output logic             REG_ACK,
  // clause-45 eee capability and advertisement inputs
  input  wire logic        C45_CAP_100,
  input  wire logic        C45_ADV_100,
  // controls out
  output eee_ctrl_t        EEE_CTRL,
  output logic [15:0]      LINK_TIMING,
  output logic [15:0]      STEP01_GAINS,
  output eee_step_t        STEP2,
  output eee_step_t        STEP3,
  output logic             WAKE_FALLBACK,
  output logic [3:0]       MSE_TIMER_CONST
);
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // one image and one next value per register
  logic [15:0] cfg_reg;      // configuration, bits 15 and 11 reserved
  logic [15:0] cfg_next;
  logic [15:0] link_reg;     // link timers and phase controls
  logic [15:0] link_next;
  logic [15:0] step01_reg;   // step 0/1 gains, every fourth bit reserved
  logic [15:0] step01_next;
  logic [15:0] step2_reg;    // step 2 gains and step sizes
  logic [15:0] step2_next;
  logic [15:0] step3_reg;    // step 3 gains and step sizes
  logic [15:0] step3_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;
  eee_ctrl_t   ctrl_reg;
  eee_ctrl_t   ctrl_next;

  // masked write merge, keeps reserved bits at zero
  function automatic logic [15:0] wmask(input logic [15:0] d, input logic [15:0] m);
    wmask = d & m;
  endfunction

  // next value of one register: masked data when written, else held
  function automatic logic [15:0] reg_update(
    input logic        we,
    input logic [15:0] cur,
    input logic [15:0] d,
    input logic [15:0] m
  );
    reg_update = we ? wmask(d, m) : cur;
  endfunction

  // address decode
  wire hit_cfg    = REG_ADDR == EEE_CFG3_OFS;
  wire hit_link   = REG_ADDR == EEE_LINK_OFS;
  wire hit_step01 = REG_ADDR == EEE_STEP01_OFS;
  wire hit_step2  = REG_ADDR == EEE_STEP2_OFS;
  wire hit_step3  = REG_ADDR == EEE_STEP3_OFS;

  // write strobes, one per register
  wire wr_cfg     = REG_WE & hit_cfg;
  wire wr_link    = REG_WE & hit_link;
  wire wr_step01  = REG_WE & hit_step01;
  wire wr_step2   = REG_WE & hit_step2;
  wire wr_step3   = REG_WE & hit_step3;

  // read selection, unmapped reads zero
  wire [15:0] rd_mux = hit_cfg    ? cfg_reg    :
                       hit_link   ? link_reg   :
                       hit_step01 ? step01_reg :
                       hit_step2  ? step2_reg  :
                       hit_step3  ? step3_reg  : 16'h0000;

  // next register values, reserved bits never stored
  assign cfg_next    = reg_update(wr_cfg, cfg_reg, REG_WDATA, EEE_CFG3_MASK);          // R13
  assign link_next   = reg_update(wr_link, link_reg, REG_WDATA, EEE_LINK_MASK);        // R8
  assign step01_next = reg_update(wr_step01, step01_reg, REG_WDATA, EEE_STEP01_MASK);  // R9 R13
  assign step2_next  = reg_update(wr_step2, step2_reg, REG_WDATA, EEE_STEPN_MASK);     // R10 R13
  assign step3_next  = reg_update(wr_step3, step3_reg, REG_WDATA, EEE_STEPN_MASK);     // R11 R13

  // read data holds between reads; ack follows any strobe by one cycle
  assign rdata_next = REG_RE ? rd_mux : rdata_reg;
  assign ack_next   = REG_WE | REG_RE;

  // ----------------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------------
  // configuration register
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      cfg_reg <= EEE_CFG3_RST;        // R6
    else
      cfg_reg <= cfg_next;
  end

  // link timing register
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      link_reg <= EEE_LINK_RST;       // R7
    else
      link_reg <= link_next;
  end

  // step 0/1 gain register
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      step01_reg <= EEE_STEP01_RST;   // R9
    else
      step01_reg <= step01_next;
  end

  // step 2 register
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      step2_reg <= EEE_STEP2_RST;     // R10
    else
      step2_reg <= step2_next;
  end

  // step 3 register
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      step3_reg <= EEE_STEP3_RST;     // R11
    else
      step3_reg <= step3_next;
  end

  // read data, taken only on a read strobe
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdata_next;
  end

  // acknowledge, one cycle after the strobe
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      ack_reg <= 1'b0;
    else
      ack_reg <= ack_next;
  end

  // ----------------------------------------------------------------------
  // decoded eee controls
  // ----------------------------------------------------------------------
  // configuration fields by name
  wire       support  = cfg_reg[EEE_SUPPORT_BIT];                  // R4 R5
  wire       adv_src  = cfg_reg[EEE_ADVSRC_BIT];                   // R1
  wire       np_block = cfg_reg[EEE_NPBLK_BIT];                    // R2
  wire       rx_pd    = cfg_reg[EEE_RXPD_BIT];                     // R3
  wire       force_tx = cfg_reg[EEE_FORCE_TX_BIT];                 // R12
  wire       c45_adv  = support & C45_CAP_100 & C45_ADV_100;       // R4 R5
  wire [1:0] force_md = cfg_reg[EEE_FORCE_LO+1:EEE_FORCE_LO];

  // decode into the control carrier
  always_comb
  begin
    ctrl_next.adv_eee      = adv_src ? support : c45_adv;          // R1
    ctrl_next.np_rx_enable = ~np_block;                            // R2
    ctrl_next.rx_pd_quiet  = rx_pd;                                // R3
    ctrl_next.force_mode   = force_md;                             // R12
    ctrl_next.force_lpi_tx = force_tx & (force_md == EEE_FORCE_LPI);  // R12
  end

  // registered control outputs
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      ctrl_reg <= '0;
    else
      ctrl_reg <= ctrl_next;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // register port answer
  assign REG_RDATA       = rdata_reg;
  assign REG_ACK         = ack_reg;
  // register images out
  assign EEE_CTRL        = ctrl_reg;
  assign LINK_TIMING     = link_reg;
  assign STEP01_GAINS    = step01_reg;
  assign STEP2           = step2_reg[$bits(eee_step_t)-1:0];
  assign STEP3           = step3_reg[$bits(eee_step_t)-1:0];
  // configuration fields out
  assign WAKE_FALLBACK   = cfg_reg[EEE_WAKE_FB_BIT];                 // R6
  assign MSE_TIMER_CONST = cfg_reg[EEE_MSE_LO+3:EEE_MSE_LO];         // R6
endmodule
`default_nettype wire

// File: shared/eee_pkg.sv
/*
  eee_pkg: offsets, field positions, reset values and carrier types for the
  low-power-idle and 100M timing-loop configuration bank.
  assumes: a plain synchronous register port with 16-bit data.
*/
`default_nettype none
package eee_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] EEE_CFG3_OFS   = 16'h04d1;
  localparam logic [15:0] EEE_LINK_OFS   = 16'h04d2;
  localparam logic [15:0] EEE_STEP01_OFS = 16'h04d4;
  localparam logic [15:0] EEE_STEP2_OFS  = 16'h04d5;
  localparam logic [15:0] EEE_STEP3_OFS  = 16'h04d6;
  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] EEE_CFG3_RST   = 16'h018b;
  localparam logic [15:0] EEE_LINK_RST   = 16'h354a;
  localparam logic [15:0] EEE_STEP01_RST = 16'h6633;
  localparam logic [15:0] EEE_STEP2_RST  = 16'h02f1;
  localparam logic [15:0] EEE_STEP3_RST  = 16'h0171;
  // ----------------------------------------------------------------------
  // writable bit masks (reserved bits read zero)
  // ----------------------------------------------------------------------
  localparam logic [15:0] EEE_CFG3_MASK   = 16'h77ff;
  localparam logic [15:0] EEE_LINK_MASK   = 16'hffff;
  localparam logic [15:0] EEE_STEP01_MASK = 16'h7777;
  localparam logic [15:0] EEE_STEPN_MASK  = 16'h03ff;
  // ----------------------------------------------------------------------
  // field positions in the configuration register
  // ----------------------------------------------------------------------
  localparam int EEE_SUPPORT_BIT   = 0;
  localparam int EEE_RXPD_BIT      = 1;
  localparam int EEE_NPBLK_BIT     = 2;
  localparam int EEE_ADVSRC_BIT    = 3;
  localparam int EEE_FORCE_TX_BIT  = 12;
  localparam int EEE_FORCE_LO      = 13;
  localparam int EEE_MSE_LO        = 4;
  localparam int EEE_WAKE_FB_BIT   = 8;
  localparam logic [1:0] EEE_FORCE_LPI = 2'h3;

  // adaptation step fields, shared by steps two and three
  typedef struct packed {
    logic [2:0] prop_gain;   // bits 9-7
    logic [2:0] freq_gain;   // bits 6-4
    logic [1:0] mse_step;    // bits 3-2
    logic       dfe_step;    // bit 1
    logic       agc_step;    // bit 0
  } eee_step_t;

  // decoded controls for the auto-negotiation and analog blocks
  typedef struct packed {
    logic       adv_eee;         // ability advertised
    logic       np_rx_enable;    // eee next pages accepted
    logic       rx_pd_quiet;     // shut analog rx in quiet
    logic       force_lpi_tx;    // forced lpi transmit request
    logic [1:0] force_mode;
  } eee_ctrl_t;
endpackage
`default_nettype wire

// File: verif/eee_regs_chk.sv
/* eee_regs_chk: port assertions for the eee configuration bank.
   assumes: bound to eee_dsp_config_registers, one clock, sync reset. */
`default_nettype none
module eee_regs_chk
  import eee_pkg::*;
(
  // clock and reset
  input wire logic        MCLK,
  input wire logic        SRST,
  // register port
  input wire logic [15:0] REG_ADDR,
  input wire logic        REG_WE,
  input wire logic        REG_RE,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic        REG_ACK,
  // clause-45 inputs
  input wire logic        C45_CAP_100,
  input wire logic        C45_ADV_100,
  // controls
  input wire eee_ctrl_t   EEE_CTRL,
  input wire logic [15:0] LINK_TIMING,
  input wire eee_step_t   STEP2,
  input wire logic        WAKE_FALLBACK,
  input wire logic [3:0]  MSE_TIMER_CONST
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  // cfg write taken, then acknowledged
  sequence cfg_wr;
    REG_WE && REG_ADDR == EEE_CFG3_OFS ##1 REG_ACK;
  endsequence
  ack_on_req_a: assert property ((REG_WE || REG_RE) |=> REG_ACK) else $error("ack missing");
  ack_idle_a: assert property (!(REG_WE || REG_RE) |=> !REG_ACK) else $error("ack without request");
  wake_fields_a: assert property (REG_WE && REG_ADDR == EEE_CFG3_OFS |=>
    {WAKE_FALLBACK, MSE_TIMER_CONST} == $past(REG_WDATA[8:4])) else $error("wake fields wrong");
  np_block_a: assert property (cfg_wr |=> EEE_CTRL.np_rx_enable == !$past(REG_WDATA[2], 2))
    else $error("next page control wrong");
  rx_powerdown_a: assert property (cfg_wr |=> EEE_CTRL.rx_pd_quiet == $past(REG_WDATA[1], 2))
    else $error("rx powerdown wrong");
  adv_source_a: assert property (cfg_wr |=> EEE_CTRL.adv_eee == ($past(REG_WDATA[0], 2) &&
    ($past(REG_WDATA[3], 2) || $past(C45_CAP_100) && $past(C45_ADV_100)))) else $error("advert wrong");
  force_mode_a: assert property (EEE_CTRL.force_lpi_tx |-> EEE_CTRL.force_mode == EEE_FORCE_LPI)
    else $error("forced tx outside forced mode");
  force_select_a: assert property (cfg_wr |=> EEE_CTRL.force_mode == $past(REG_WDATA[14:13], 2))
    else $error("forced select wrong");
  force_tx_a: assert property (cfg_wr |=> EEE_CTRL.force_lpi_tx ==
    ($past(REG_WDATA[12], 2) && $past(REG_WDATA[14:13], 2) == EEE_FORCE_LPI)) else $error("forced tx wrong");
  link_write_a: assert property (REG_WE && REG_ADDR == EEE_LINK_OFS |=> LINK_TIMING == $past(REG_WDATA))
    else $error("link timing wrong");
  step_write_a: assert property (REG_WE && REG_ADDR == EEE_STEP2_OFS |=> STEP2 == $past(REG_WDATA[9:0]))
    else $error("step two wrong");
  rsv_read_a: assert property (REG_RE && REG_ADDR == EEE_STEP01_OFS |=> (REG_RDATA & 16'h8888) == 16'h0)
    else $error("reserved bits set");
endmodule
bind eee_dsp_config_registers eee_regs_chk chk_u (.MCLK, .SRST, .REG_WE, .REG_RE, .REG_ACK, .C45_CAP_100, .C45_ADV_100,
  .WAKE_FALLBACK, .REG_ADDR, .REG_WDATA, .REG_RDATA, .LINK_TIMING, .MSE_TIMER_CONST, .EEE_CTRL, .STEP2);
`default_nettype wire

// File: verif/eee_regs_bench.sv
/* eee_dsp_config_registers_bench: self-checking bench for the eee configuration bank.
   assumes: package, design and checker compiled first. */
`default_nettype none
module eee_dsp_config_registers_bench
  import eee_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK = 1'h0, SRST = 1'h1, REG_WE = 1'h0, REG_RE = 1'h0, C45_CAP_100 = 1'h0, C45_ADV_100 = 1'h0;
  logic        REG_ACK, WAKE_FALLBACK;
  logic [15:0] REG_ADDR = 16'h0, REG_WDATA = 16'h0, REG_RDATA, LINK_TIMING, STEP01_GAINS;
  logic [3:0]  MSE_TIMER_CONST;
  eee_ctrl_t   EEE_CTRL;
  eee_step_t   STEP2, STEP3;
  logic [16:0] q[$], n17;
  logic [15:0] mdl[6], ofs[6], msk[6];
  int          err_total = 0, check_count = 0, seed = 76154, k;
  eee_dsp_config_registers dut_u (.MCLK, .SRST, .REG_ADDR, .REG_WE, .REG_RE, .REG_WDATA, .REG_RDATA, .REG_ACK,
    .C45_CAP_100,
    .C45_ADV_100, .EEE_CTRL, .LINK_TIMING, .STEP01_GAINS, .STEP2, .STEP3, .WAKE_FALLBACK, .MSE_TIMER_CONST);
  // 40 mhz clock
  initial forever #12.5 MCLK = ~MCLK;
  task automatic chk(input string nm, input logic [15:0] e, s);
    check_count++;
    if (e !== s)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one request per falling edge, note of expected read queued
  task automatic req(input logic w, input int i, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    // forced tx asked for only once forced lpi is already selected
    if (w && i == 0 && mdl[0][EEE_FORCE_LO+1:EEE_FORCE_LO] != EEE_FORCE_LPI)
      v[EEE_FORCE_TX_BIT] = 1'h0;
    @(negedge MCLK);
    REG_WE <= w;
    REG_RE <= !w;
    REG_ADDR <= ofs[i];
    REG_WDATA <= v;
    C45_CAP_100 <= 1'($random(seed));
    C45_ADV_100 <= 1'($random(seed));
    if (w)
      mdl[i] = v & msk[i];
    q.push_back({!w, mdl[i]});
  endtask
  task automatic idle;
    @(negedge MCLK);
    REG_WE <= 1'h0;
    REG_RE <= 1'h0;
  endtask
  // cfg write, then decoded controls two edges on
  task automatic ctl(input logic [15:0] d, input logic [15:0] e);
    req(1'h1, 0, d);
    idle();
    @(negedge MCLK);
    chk("ctrl", e, {10'h0, EEE_CTRL});
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // oldest note taken on each acknowledge
  always @(negedge MCLK)
  begin
    if (REG_ACK === 1'h1)
    begin
      n17 = q.pop_front();
      if (n17[16])
        chk("rdata", n17[15:0], REG_RDATA);
    end
  end
  // watchdog, far beyond the 109 cycles needed
  initial
  begin
    #50us;
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    ofs = '{EEE_CFG3_OFS, EEE_LINK_OFS, EEE_STEP01_OFS, EEE_STEP2_OFS, EEE_STEP3_OFS, 16'h04d3};
    msk = '{EEE_CFG3_MASK, EEE_LINK_MASK, EEE_STEP01_MASK, EEE_STEPN_MASK, EEE_STEPN_MASK, 16'h0};
    mdl = '{EEE_CFG3_RST, EEE_LINK_RST, EEE_STEP01_RST, EEE_STEP2_RST, EEE_STEP3_RST, 16'h0};
    repeat (8) @(negedge MCLK);
    SRST <= 1'h0;
    repeat (2) @(negedge MCLK);
    chk("ctrl", 16'h0038, {10'h0, EEE_CTRL});
    chk("wake", 16'h0018, {11'h0, WAKE_FALLBACK, MSE_TIMER_CONST});
    for (k = 0; k < 6; k++)
      req(1'h0, k, 16'h0);
    repeat (40)
    begin
      k = {$random(seed)} % 6;
      req(1'h1, k, 16'($random(seed)));
      req(1'h0, k, 16'h0);
    end
    ctl(16'h100b, 16'h0038);
    ctl(16'h6000, 16'h0013);
    ctl(16'h7000, 16'h0017);
    idle();
    repeat (3) @(negedge MCLK);
    chk("link", mdl[1], LINK_TIMING);
    chk("step01", mdl[2], STEP01_GAINS);
    chk("step2", mdl[3], {6'h0, STEP2});
    chk("step3", mdl[4], {6'h0, STEP3});
    chk("pending", 16'h0, 16'(q.size()));
    tally_and_finish();
  end
endmodule
`default_nettype wire
